/* File: logic/qd_dac_ctrl.sv */
// The placing of the registers and register access over AHB-Lite were decided locally.
module qd_dac_ctrl #(
  parameter logic VAR_RST = 1'b0
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic ADD_I,
  output logic [qd_pkg::NUM_CH*qd_pkg::CODE_W-1:0] ACTIVE_CODE,
  output logic [qd_pkg::NUM_CH*2-1:0] POWER_DOWN_STATE
);
  import qd_pkg::*;

  qd_line_if ln ();

  logic [NUM_CH-1:0][CODE_W-1:0] hold_ff;
  logic [NUM_CH-1:0][CODE_W-1:0] act_ff;
  logic [NUM_CH-1:0][1:0] pd_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  qd_state_t state_ff;
  qd_byte_t byte_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [NIB_W-1:0] cmd_ff;
  logic [NIB_W-1:0] upper_ff;
  logic [CH_W-1:0] rd_ch_ff;
  logic rw_ff;
  logic ack_on_ff;
  logic mack_ok_ff;
  logic tx_idx_ff;
  logic seen_clk_ff;
  logic sda_oe_ff;
  logic sda_o_ff;
  logic hready_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;

  logic en;
  logic [6:0] slave_id;
  logic ack_end;
  logic [CODE_W-1:0] new_code;
  logic [7:0] tx_first;
  logic [7:0] tx_second;
  logic bus_take;

  if (NUM_CH != 4 || CODE_W != NIB_W + TX_LO_W) begin : g_chk
    $error("qd_dac_ctrl serves four 10-bit channels only");
  end

  qd_line_sync #(
    .STAGES(2)
  ) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .scl_pin(SCL_I),
    .sda_pin(SDA_I),
    .add_pin(ADD_I),
    .ln(ln)
  );

  // Slave id: variant picks the fixed part, pin the last bit
  assign en = ctrl_ff[CTRL_EN_BIT];
  assign slave_id = {ctrl_ff[CTRL_VAR_BIT] ? ID_UPPER_M : ID_UPPER_L, ln.add_lvl};
  assign ack_end = CE && en && !ln.start && !(ln.stop && seen_clk_ff)
                   && state_ff == ST_ACK && ack_on_ff && ln.scl_fall;
  // Trailing two bits are ignored as the master sends them zero
  assign new_code = {upper_ff, shift_ff[7:2]};
  assign tx_first = 8'(act_ff[rd_ch_ff][CODE_W-1:TX_LO_W]);
  assign tx_second = {act_ff[rd_ch_ff][TX_LO_W-1:0], TRAIL_ZERO};
  assign bus_take = HSEL && HREADY && HTRANS[HTRANS_ACT_BIT];

  // A clock pulse since START arms STOP detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      seen_clk_ff <= 1'b0;
    end else if (CE) begin
      if (ln.start) begin
        seen_clk_ff <= 1'b0;
      end else if (ln.scl_rise) begin
        seen_clk_ff <= 1'b1;
      end
    end
  end

  // Serial protocol engine; all steps but the drop to idle on disable ride on sampled line events
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_ff <= ST_IDLE;
      byte_ff <= BY_ADDR;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      cmd_ff <= '0;
      upper_ff <= '0;
      rd_ch_ff <= '0;
      rw_ff <= 1'b0;
      ack_on_ff <= 1'b0;
      mack_ok_ff <= 1'b0;
      tx_idx_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (CE) begin
      if (!en) begin
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (ln.start) begin
        // START or repeated START restarts address matching
        state_ff <= ST_ADDR;
        byte_ff <= BY_ADDR;
        bit_cnt_ff <= '0;
        ack_on_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (ln.stop && seen_clk_ff) begin
        // Abandons any half-written word, nothing is applied
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
            // Clock ignored until the next START
            sda_oe_ff <= 1'b0;
          end
          ST_ADDR: begin
            if (ln.scl_rise) begin
              shift_ff <= {shift_ff[6:0], ln.sda};
              if (bit_cnt_ff == LAST_BIT) begin
                rw_ff <= ln.sda;
                state_ff <= ST_ACK;
                bit_cnt_ff <= '0;
              end else if (ln.sda != slave_id[ID_MSB - bit_cnt_ff]) begin
                // General call never matches a non-zero id
                state_ff <= ST_IDLE;
              end else begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
              end
            end
          end
          ST_RX: begin
            if (ln.scl_rise) begin
              shift_ff <= {shift_ff[6:0], ln.sda};
              if (bit_cnt_ff == LAST_BIT) begin
                state_ff <= ST_ACK;
                bit_cnt_ff <= '0;
              end else begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
              end
            end
          end
          ST_ACK: begin
            if (ln.scl_fall && !ack_on_ff) begin
              sda_oe_ff <= 1'b1;
              ack_on_ff <= 1'b1;
            end else if (ln.scl_fall) begin
              ack_on_ff <= 1'b0;
              sda_oe_ff <= 1'b0;
              state_ff <= ST_RX;
              byte_ff <= BY_CMD;
              unique case (byte_ff)
                BY_ADDR: begin
                  if (rw_ff) begin
                    // First read bit goes out on the fall that ends the ack
                    state_ff <= ST_TX;
                    tx_idx_ff <= 1'b0;
                    sda_oe_ff <= ~tx_first[7];
                    shift_ff <= {tx_first[6:0], 1'b0};
                  end
                end
                BY_CMD: begin
                  cmd_ff <= shift_ff[7:4];
                  upper_ff <= shift_ff[3:0];
                  if (shift_ff[7:4] == CMD_EXT && shift_ff[3:0] == EXT_UPPER) begin
                    byte_ff <= BY_EXT;
                  end else if (shift_ff[7:4] == CMD_EXT) begin
                    if ($onehot(shift_ff[3:0])) begin
                      rd_ch_ff <= shift_ff[1] ? 2'h1 : shift_ff[2] ? 2'h2 :
                                  shift_ff[3] ? 2'h3 : 2'h0;
                    end
                  end else if (shift_ff[7:4] != CMD_UPDATE) begin
                    // Update-all takes no data byte
                    byte_ff <= BY_DATA;
                  end
                end
                default: begin
                  // Data or extended byte done; next byte is a new command
                  byte_ff <= BY_CMD;
                end
              endcase
            end
          end
          ST_TX: begin
            if (ln.scl_rise && bit_cnt_ff == LAST_BIT) begin
              state_ff <= ST_MACK;
              bit_cnt_ff <= '0;
              ack_on_ff <= 1'b0;
            end else if (ln.scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end else if (ln.scl_fall) begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
          ST_MACK: begin
            if (ln.scl_fall && !ack_on_ff) begin
              sda_oe_ff <= 1'b0;
            end else if (ln.scl_rise) begin
              ack_on_ff <= 1'b1;
              mack_ok_ff <= ~ln.sda;
            end else if (ln.scl_fall && mack_ok_ff && !tx_idx_ff) begin
              // Second byte only after the master's acknowledge
              state_ff <= ST_TX;
              tx_idx_ff <= 1'b1;
              ack_on_ff <= 1'b0;
              sda_oe_ff <= ~tx_second[7];
              shift_ff <= {tx_second[6:0], 1'b0};
            end else if (ln.scl_fall) begin
              // Not acknowledged or done; wait for STOP
              state_ff <= ST_IDLE;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Code registers change only at the end of a completed byte
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hold_ff <= '0;
      act_ff <= '0;
    end else if (ack_end && byte_ff == BY_DATA) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (cmd_ff < CMD_HOLD_BASE) begin
          if (cmd_ff[CH_W-1:0] == CH_W'(ch)) begin
            hold_ff[ch] <= new_code;
            act_ff[ch] <= new_code;
          end else begin
            act_ff[ch] <= hold_ff[ch];
          end
        end else if (cmd_ff < CMD_XFER_BASE) begin
          if (cmd_ff[CH_W-1:0] == CH_W'(ch)) begin
            hold_ff[ch] <= new_code;
          end
        end else if (cmd_ff < CMD_LOAD_ALL) begin
          // Outputs take the old holding codes before the new load
          act_ff[ch] <= hold_ff[ch];
          if (cmd_ff[CH_W-1:0] == CH_W'(ch)) begin
            hold_ff[ch] <= new_code;
          end
        end else if (cmd_ff == CMD_LOAD_ALL) begin
          hold_ff[ch] <= new_code;
          act_ff[ch] <= new_code;
        end else begin
          hold_ff[ch] <= new_code;
        end
      end
    end else if (ack_end && byte_ff == BY_CMD && shift_ff[7:4] == CMD_UPDATE) begin
      act_ff <= hold_ff;
    end
  end

  // Per-channel power-down state; codes stay as they are
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pd_ff <= {NUM_CH{PD_100K}};
    end else if (ack_end && byte_ff == BY_EXT) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (shift_ff[EXT_SEL_LSB + ch]) begin
          pd_ff[ch] <= shift_ff[PD_SEL_LSB +: 2];
        end
      end
    end
  end

  // Bus slave: zero wait, always OKAY
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hready_ff <= 1'b0;
      hresp_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else if (CE) begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
  end

  // Write address captured in the address phase, data used one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      ctrl_ff <= {VAR_RST, 1'b1};
    end else if (CE) begin
      wr_pend_ff <= bus_take && HWRITE && HSIZE == HSIZE_WORD;
      wr_addr_ff <= HADDR[7:0];
      if (wr_pend_ff && wr_addr_ff == OFS_CTRL) begin
        ctrl_ff <= HWDATA[CTRL_W-1:0];
      end
    end
  end

  // Read data prepared at the address phase; unmapped reads give zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hrdata_ff <= '0;
    end else if (CE) begin
      hrdata_ff <= '0;
      if (bus_take && !HWRITE && HADDR[1:0] == 2'h0 && HADDR[31:8] == 24'h0) begin
        if (HADDR[7:0] == OFS_CTRL) begin
          hrdata_ff <= 32'({state_ff, ctrl_ff});
        end else if (HADDR[7:0] == OFS_PD) begin
          hrdata_ff <= 32'(pd_ff);
        end else if ({HADDR[7:4], OFS_LOW_ZERO} == OFS_ACT) begin
          hrdata_ff <= 32'(act_ff[HADDR[3:2]]);
        end else if ({HADDR[7:4], OFS_LOW_ZERO} == OFS_HOLD) begin
          hrdata_ff <= 32'(hold_ff[HADDR[3:2]]);
        end
      end
    end
  end

  assign HREADYOUT = hready_ff;
  assign HRESP = hresp_ff;
  assign HRDATA = hrdata_ff;
  assign SDA_O = sda_o_ff;
  assign SDA_OE = sda_oe_ff;
  assign ACTIVE_CODE = act_ff;
  assign POWER_DOWN_STATE = pd_ff;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_reset_state: assert property ($past(RST) |-> act_ff == '0 && pd_ff == {NUM_CH{PD_100K}})
    else $error("reset did not clear codes or power down");
  a_ack_low: assert property (state_ff == ST_ACK && ack_on_ff |-> sda_oe_ff)
    else $error("acknowledge not driven low");
  a_master_ack_free: assert property (state_ff == ST_MACK && ack_on_ff |-> !sda_oe_ff)
    else $error("data line held during master acknowledge");
  a_idle_quiet: assert property (state_ff == ST_IDLE && !ln.start |=> state_ff == ST_IDLE && !sda_oe_ff)
    else $error("idle engine reacted to the clock");
  a_addr_mismatch: assert property (CE && en && state_ff == ST_ADDR && ln.scl_rise && !ln.start
    && bit_cnt_ff != LAST_BIT && ln.sda != slave_id[ID_MSB - bit_cnt_ff] |=> state_ff == ST_IDLE)
    else $error("mismatching address bit not abandoned");
  a_hold_only: assert property (ack_end && byte_ff == BY_DATA && cmd_ff >= CMD_HOLD_BASE
    && cmd_ff < CMD_XFER_BASE |=> $stable(act_ff) && hold_ff[$past(cmd_ff[CH_W-1:0])] == $past(new_code))
    else $error("holding-only command disturbed outputs");
  a_load_both: assert property (ack_end && byte_ff == BY_DATA && cmd_ff < CMD_HOLD_BASE
    |=> act_ff[$past(cmd_ff[CH_W-1:0])] == $past(new_code))
    else $error("direct load missed the active code");
  a_update_all: assert property (ack_end && byte_ff == BY_CMD && shift_ff[7:4] == CMD_UPDATE
    |=> act_ff == $past(hold_ff))
    else $error("update did not copy holding codes");
  a_pd_keeps_codes: assert property (ack_end && byte_ff == BY_EXT
    |=> $stable(act_ff) && $stable(hold_ff))
    else $error("power-down command changed codes");
  a_pd_unselected: assert property (ack_end && byte_ff == BY_EXT && !shift_ff[EXT_SEL_LSB]
    |=> $stable(pd_ff[0]))
    else $error("unselected channel power state changed");
  a_stop_ends: assert property (CE && en && !ln.start && ln.stop && seen_clk_ff
    |=> state_ff == ST_IDLE && !sda_oe_ff)
    else $error("stop not honoured");

  c_data_write: cover property (ack_end && byte_ff == BY_DATA);
  c_ext_write: cover property (ack_end && byte_ff == BY_EXT);
  c_read_second: cover property (state_ff == ST_TX && tx_idx_ff);
  c_addr_reject: cover property (state_ff == ST_ADDR ##1 state_ff == ST_IDLE);
endmodule

/* File: logic/qd_pkg.sv */
package qd_pkg;
  // Converter geometry: straight binary code, 0 to 1023
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int CODE_W = 10;
  localparam int NIB_W = 4;
  localparam int TX_LO_W = 6;
  localparam logic [1:0] TRAIL_ZERO = 2'h0;

  // Register offsets, byte addresses on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PD = 8'h04;
  localparam logic [7:0] OFS_ACT = 8'h10;
  localparam logic [7:0] OFS_HOLD = 8'h20;
  localparam logic [3:0] OFS_LOW_ZERO = 4'h0;

  // Control register fields and width
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_VAR_BIT = 1;
  localparam int CTRL_W = 2;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT_BIT = 1;

  // Power-down selector codes
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_FLOAT = 2'h1;
  localparam logic [1:0] PD_1K = 2'h2;
  localparam logic [1:0] PD_100K = 2'h3;

  // Fixed upper six slave-id bits per variant
  localparam logic [5:0] ID_UPPER_L = 6'h1e;
  localparam logic [5:0] ID_UPPER_M = 6'h2e;
  localparam logic [2:0] ID_MSB = 3'h6;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Command nibble codes
  localparam logic [3:0] CMD_HOLD_BASE = 4'h4;
  localparam logic [3:0] CMD_XFER_BASE = 4'h8;
  localparam logic [3:0] CMD_LOAD_ALL = 4'hc;
  localparam logic [3:0] CMD_HOLD_ALL = 4'hd;
  localparam logic [3:0] CMD_UPDATE = 4'he;
  localparam logic [3:0] CMD_EXT = 4'hf;
  localparam logic [3:0] EXT_UPPER = 4'h0;
  localparam int EXT_SEL_LSB = 2;
  localparam int PD_SEL_LSB = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_RX = 3'h2,
    ST_ACK = 3'h3,
    ST_TX = 3'h4,
    ST_MACK = 3'h5
  } qd_state_t;

  typedef enum logic [1:0] {
    BY_ADDR = 2'h0,
    BY_CMD = 2'h1,
    BY_DATA = 2'h2,
    BY_EXT = 2'h3
  } qd_byte_t;
endpackage

/* File: logic/qd_line_if.sv */
// Conditioned two-wire line events, all on the system clock
interface qd_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  logic add_lvl;
  modport src (output scl_rise, scl_fall, sda, start, stop, add_lvl);
  modport dst (input scl_rise, scl_fall, sda, start, stop, add_lvl);
endinterface

/* File: logic/qd_line_sync.sv */
module qd_line_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic add_pin,
  qd_line_if.src ln
);
  import qd_pkg::*;

  if (STAGES < 2) begin : g_chk
    $error("qd_line_sync needs at least two synchroniser stages");
  end

  logic [STAGES-1:0] scl_sync_ff;
  logic [STAGES-1:0] sda_sync_ff;
  logic [STAGES-1:0] add_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;

  // Pins are asynchronous; only the chain reads its first stage
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_ff <= '1;
      sda_sync_ff <= '1;
      add_sync_ff <= '0;
    end else if (ce) begin
      scl_sync_ff <= {scl_sync_ff[STAGES-2:0], scl_pin};
      sda_sync_ff <= {sda_sync_ff[STAGES-2:0], sda_pin};
      add_sync_ff <= {add_sync_ff[STAGES-2:0], add_pin};
    end
  end

  // Edge history; idle-high so reset makes no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else if (ce) begin
      scl_prev_ff <= scl_sync_ff[STAGES-1];
      sda_prev_ff <= sda_sync_ff[STAGES-1];
    end
  end

  // Clock is only sampled, never driven by this end
  assign ln.scl_rise = ce & scl_sync_ff[STAGES-1] & ~scl_prev_ff;
  assign ln.scl_fall = ce & ~scl_sync_ff[STAGES-1] & scl_prev_ff;
  assign ln.sda = sda_sync_ff[STAGES-1];
  assign ln.add_lvl = add_sync_ff[STAGES-1];
  // Data edges while the clock stays high frame a transfer
  assign ln.start = ce & scl_sync_ff[STAGES-1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[STAGES-1];
  assign ln.stop = ce & scl_sync_ff[STAGES-1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[STAGES-1];

  a_start_decode: assert property (@(posedge clk) disable iff (rst)
    ln.start |-> !ln.stop && !ln.scl_rise && !ln.scl_fall)
    else $error("start coincides with another line event");
endmodule

/* File: test/qd_master_model.sv */
// Two-wire bus master; the bench calls its tasks to frame traffic
module qd_master_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: both lines high, clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One clock of 13 low plus 12 high cycles, 125 ns; data moves while low
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(6);
    sda <= b;
    tick(7);
    scl <= 1'b1;
    tick(6);
    r = sda_in;
    tick(6);
  endtask
  // Start (1,0) or stop (0,1); always after a full clock pulse
  task automatic edge_cond(input logic a, input logic b);
    scl <= 1'b0;
    tick(6);
    sda <= a;
    tick(7);
    scl <= 1'b1;
    tick(6);
    sda <= b;
    tick(13);
  endtask
  // MSB first, ninth clock with the line let go for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  // Last read byte is left unacknowledged, then the caller stops
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mack, r);
  endtask
endmodule

/* File: test/tb_quad_dac_i2c_control.sv */
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_quad_dac_i2c_control;
  timeunit 1ns;
  timeprecision 1ps;
  import qd_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dat;
    logic has_dat;
    logic [39:0] act;
    logic [7:0] pd;
  } qd_row_t;
  localparam logic [7:0] ADDR_W = {ID_UPPER_L, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic add = 1'b0;
  logic hready, hresp, scl, m_sda, sda_o, sda_oe;
  logic [31:0] hrdata;
  logic [39:0] act;
  logic [7:0] pd;
  int cycles = 0;
  int tests_run = 0;
  int miscompares = 0;
  logic [7:0] bad_ids [3] = '{8'h7a, 8'h00, 8'hf8};
  // Write rows: command byte, data byte, data sent, outputs after stop
  qd_row_t rows [17] = '{
    '{8'hf0, 8'h3c, 1'b1, 40'h0, 8'h00}, '{8'hf0, 8'h07, 1'b1, 40'h0, 8'h03},
    '{8'hf0, 8'h09, 1'b1, 40'h0, 8'h07}, '{8'hf0, 8'h12, 1'b1, 40'h0, 8'h27},
    '{8'h4f, 8'hfc, 1'b1, 40'h0, 8'h27}, '{8'h55, 8'h54, 1'b1, 40'h0, 8'h27},
    '{8'h1a, 8'ha8, 1'b1, 40'haabff, 8'h27}, '{8'hd0, 8'h04, 1'b1, 40'haabff, 8'h27},
    '{8'hb8, 8'h00, 1'b1, 40'h40100401, 8'h27}, '{8'he0, 8'h00, 1'b0, 40'h8000100401, 8'h27},
    '{8'hcf, 8'hfc, 1'b1, 40'hffffffffff, 8'h27}, '{8'h20, 8'h00, 1'b1, 40'hffc00fffff, 8'h27},
    '{8'h35, 8'h54, 1'b1, 40'h55400fffff, 8'h27}, '{8'h70, 8'h00, 1'b1, 40'h55400fffff, 8'h27},
    '{8'h84, 8'h8c, 1'b1, 40'hfffff, 8'h27}, '{8'he0, 8'h00, 1'b0, 40'hffd23, 8'h27},
    '{8'h00, 8'h00, 1'b1, 40'hffc00, 8'h27}};
  // Open-drain data line: pulled up, low if either party pulls
  wire sda_line = m_sda & (~sda_oe | sda_o);

  qd_dac_ctrl u_qd_dac_ctrl (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .ADD_I(add), .ACTIVE_CODE(act), .POWER_DOWN_STATE(pd));
  qd_master_model u_qd_master_model (.clk(clk), .sda_in(sda_line), .scl(scl), .sda(m_sda));

  // 200 MHz system clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Single word transfer; no fixed latency assumed
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr_byte(input logic [7:0] d, input logic ea);
    logic a;
    u_qd_master_model.wbyte(d, a);
    `CHK(a, ea)
  endtask
  // Whole write frame to id aw; trailing zero bits sit in the data rows
  task automatic wr_seq(input logic [7:0] aw, input logic [7:0] c, input logic [7:0] d,
                        input logic hd, input logic ea);
    u_qd_master_model.edge_cond(1'b1, 1'b0);
    wr_byte(aw, ea);
    wr_byte(c, ea);
    if (hd) wr_byte(d, ea);
    u_qd_master_model.edge_cond(1'b0, 1'b1);
  endtask

  // Main sequence: reset, rows, then the awkward cases
  initial begin
    logic [31:0] rd;
    logic [7:0] b1, b2;
    logic a;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(act, 40'h0)
    `CHK(pd, 8'hff)
    `CHK({hready, hresp, sda_o, sda_oe}, 4'h8)
    ahb(1'b0, {24'h0, OFS_CTRL}, 32'h0, rd);
    `CHK(rd[1:0], 2'b01)
    ahb(1'b0, 32'h40, 32'h0, rd);
    `CHK(rd, 32'h0)
    foreach (rows[i]) begin
      wr_seq(ADDR_W, rows[i].cmd, rows[i].dat, rows[i].has_dat, 1'b0);
      `CHK(act, rows[i].act)
      `CHK(pd, rows[i].pd)
    end
    ahb(1'b0, {24'h0, OFS_PD}, 32'h0, rd);
    `CHK(rd, 32'h27)
    ahb(1'b0, {24'h0, OFS_ACT} + 32'h4, 32'h0, rd);
    `CHK(rd, 32'h3ff)
    // Read back channel B across a repeated start
    u_qd_master_model.edge_cond(1'b1, 1'b0);
    wr_byte(ADDR_W, 1'b0);
    wr_byte(8'hf2, 1'b0);
    u_qd_master_model.edge_cond(1'b1, 1'b0);
    wr_byte(ADDR_W | 8'h01, 1'b0);
    u_qd_master_model.rbyte(1'b0, b1);
    u_qd_master_model.rbyte(1'b1, b2);
    u_qd_master_model.edge_cond(1'b0, 1'b1);
    `CHK({b1, b2}, 16'h0ffc)
    // Stop just after the eighth data bit, before its ack, changes nothing
    u_qd_master_model.edge_cond(1'b1, 1'b0);
    wr_byte(ADDR_W, 1'b0);
    wr_byte(8'h05, 1'b0);
    repeat (7) u_qd_master_model.bit_io(1'b1, a);
    u_qd_master_model.edge_cond(1'b0, 1'b1);
    `CHK(act, 40'hffc00)
    // Foreign, general call and ten-bit ids get no ack and no effect
    foreach (bad_ids[i]) begin
      wr_seq(bad_ids[i], 8'hc0, 8'h00, 1'b1, 1'b1);
      `CHK(act, 40'hffc00)
    end
    // Three words chained in one frame without a repeated start
    u_qd_master_model.edge_cond(1'b1, 1'b0);
    wr_byte(ADDR_W, 1'b0);
    wr_byte(8'hc0, 1'b0);
    wr_byte(8'h00, 1'b0);
    wr_byte(8'h2f, 1'b0);
    wr_byte(8'hfc, 1'b0);
    wr_byte(8'h50, 1'b0);
    wr_byte(8'h04, 1'b0);
    u_qd_master_model.edge_cond(1'b0, 1'b1);
    `CHK(act, 40'h3ff00000)
    ahb(1'b0, {24'h0, OFS_HOLD} + 32'h4, 32'h0, rd);
    `CHK(rd, 32'h1)
    // Serial side ignored while the bus disables it: no ack at all
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h0, rd);
    wr_seq(ADDR_W, 8'hcf, 8'hfc, 1'b1, 1'b1);
    `CHK(act, 40'h3ff00000)
    // Other variant with the select pin high answers its own id only
    add <= 1'b1;
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h3, rd);
    wr_seq(ADDR_W | 8'h02, 8'hcf, 8'hfc, 1'b1, 1'b1);
    `CHK(act, 40'h3ff00000)
    wr_seq({ID_UPPER_M, 2'b10}, 8'hcf, 8'hfc, 1'b1, 1'b0);
    `CHK(act, 40'hffffffffff)
    // Reset in mid run restores the power-on state
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(act, 40'h0)
    `CHK(pd, 8'hff)
    ahb(1'b0, {24'h0, OFS_CTRL}, 32'h0, rd);
    `CHK(rd[1:0], 2'b01)
    complete_run();
  end
endmodule
